// [logic/rfc_pkg.sv]
package rfc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  AUTO_FLOW_CONTROL_CONFIG_OFFSET   = 8'hac;
  localparam logic [31:0] AUTO_FLOW_CONTROL_CONFIG_RESET    = 32'h0000_0000;
  localparam int          HI_MARK_MSB      = 23;
  localparam int          HI_MARK_LSB      = 16;
  localparam int          LO_MARK_MSB      = 15;
  localparam int          LO_MARK_LSB      = 8;
  localparam int          BP_DUR_MSB       = 7;
  localparam int          BP_DUR_LSB       = 4;
  localparam int          TRIG_MCAST_BIT   = 3;
  localparam int          TRIG_BCAST_BIT   = 2;
  localparam int          TRIG_OWN_BIT     = 1;
  localparam int          TRIG_ANY_BIT     = 0;
  localparam logic [31:0] AUTO_FLOW_CONTROL_CONFIG_WMASK    = 32'h00ff_ffff;

  // ----------------------------------------
  // Fill level units
  // ----------------------------------------
  localparam int          MARK_UNIT_SHIFT  = 6;

  // ----------------------------------------
  // Backpressure timing
  // ----------------------------------------
  localparam int          CLK_MHZ          = 20;
  localparam int          SLOW_EXTRA_NS    = 2200;
  localparam int          SLOW_EXTRA_CYC   = (SLOW_EXTRA_NS * CLK_MHZ) / 1000;
  localparam int          BP_CNT_W         = 14;

  typedef enum logic [1:0] {
    RFC_IDLE,
    RFC_ARMED,
    RFC_PAUSED
  } rfc_state_e;

endpackage

// [logic/rfc_dur_rom.sv]
`timescale 1ns/100ps
module rfc_dur_rom
  import rfc_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic [3:0]          code_i,
  input  wire logic                slow_i,
  output logic [BP_CNT_W-1:0]      cycles_o
);

  // ----------------------------------------
  // Duration table in microseconds
  // ----------------------------------------
  localparam int DUR_US [16] = '{5, 10, 15, 25, 50, 100, 150, 200,
                                 250, 300, 350, 400, 450, 500, 550, 600};

  function automatic logic [BP_CNT_W-1:0] dur_cycles(input logic [3:0] c,
                                                     input logic       s);
    int n;
    n = DUR_US[c] * CLK_MHZ;
    if (s) begin
      n = n + SLOW_EXTRA_CYC;
    end
    return BP_CNT_W'(n);
  endfunction

  // Registered read keeps the counter load off a long table path
  always_ff @(posedge clk_i) begin
    cycles_o <= dur_cycles(code_i, slow_i);
  end

endmodule

// [logic/rfc_flow_ctrl.sv]
`timescale 1ns/100ps
module rfc_flow_ctrl
  import rfc_pkg::*;
#(
  parameter int FIFO_LVL_W = 14
)
(
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [31:0]           reg_wdata_i,
  output logic [31:0]                reg_rdata_o,
  input  wire logic [FIFO_LVL_W-1:0] rx_fifo_used_i,
  input  wire logic                  tx_enabled_i,
  input  wire logic                  full_duplex_i,
  input  wire logic                  speed_10_i,
  input  wire logic                  rx_preamble_i,
  input  wire logic                  rx_addr_valid_i,
  input  wire logic                  rx_is_mcast_i,
  input  wire logic                  rx_is_bcast_i,
  input  wire logic                  rx_is_own_i,
  input  wire logic                  pause_ack_i,
  output logic                       pause_req_o,
  output logic                       pause_zero_o,
  output logic                       backpressure_o,
  output logic                       paused_o
);
  import rfc_pkg::*;

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  logic [31:0]         cfg_ff;
  logic [7:0]          high_water_mark;
  logic [7:0]          low_water_mark;
  logic [3:0]          backpressure_duration;
  logic                trigger_on_multicast;
  logic                trigger_on_broadcast;
  logic                trigger_on_own_address;
  logic                trigger_on_any_frame;
  logic                fc_enabled;

  assign high_water_mark        = cfg_ff[HI_MARK_MSB:HI_MARK_LSB];
  assign low_water_mark         = cfg_ff[LO_MARK_MSB:LO_MARK_LSB];
  assign backpressure_duration  = cfg_ff[BP_DUR_MSB:BP_DUR_LSB];
  assign trigger_on_multicast   = cfg_ff[TRIG_MCAST_BIT];
  assign trigger_on_broadcast   = cfg_ff[TRIG_BCAST_BIT];
  assign trigger_on_own_address = cfg_ff[TRIG_OWN_BIT];
  assign trigger_on_any_frame   = cfg_ff[TRIG_ANY_BIT];
  assign fc_enabled             = |cfg_ff[TRIG_MCAST_BIT:TRIG_ANY_BIT];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_ff <= AUTO_FLOW_CONTROL_CONFIG_RESET;
    end else if (reg_wr_i && reg_addr_i == AUTO_FLOW_CONTROL_CONFIG_OFFSET) begin
      cfg_ff <= reg_wdata_i & AUTO_FLOW_CONTROL_CONFIG_WMASK;
    end
  end

  // ----------------------------------------
  // Level compare
  // ----------------------------------------
  function automatic logic [FIFO_LVL_W+1:0] mark_bytes(input logic [7:0] m);
    return (FIFO_LVL_W + 2)'(m) << MARK_UNIT_SHIFT;
  endfunction

  logic [FIFO_LVL_W+1:0] used_w;
  logic                  at_high_ff;
  logic                  below_low_ff;

  assign used_w = (FIFO_LVL_W + 2)'(rx_fifo_used_i);

  // Registered so the FIFO_LVL_W+2 bit level-to-mark compare stays off the request path
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      at_high_ff   <= 1'b0;
      below_low_ff <= 1'b0;
    end else begin
      at_high_ff   <= used_w >= mark_bytes(high_water_mark);
      below_low_ff <= used_w < mark_bytes(low_water_mark);
    end
  end

  // ----------------------------------------
  // Full-duplex pause sequencing
  // ----------------------------------------
  rfc_state_e state_ff;
  rfc_state_e nxt_state;
  logic       nxt_pause_req;
  logic       nxt_pause_zero;

  always_comb begin
    nxt_state      = state_ff;
    nxt_pause_req  = pause_req_o;
    nxt_pause_zero = pause_zero_o;
    case (state_ff)
      RFC_IDLE: begin
        // Any-frame bit enables full-duplex arming; the zero pause from paused needs only any trigger bit
        if (full_duplex_i && trigger_on_any_frame && tx_enabled_i) begin
          nxt_state = RFC_ARMED;
        end
      end
      RFC_ARMED: begin
        // A queued request is seen through to its ack so it cannot strand in idle
        if (pause_req_o) begin
          if (pause_ack_i) begin
            nxt_pause_req = 1'b0;
            nxt_state     = RFC_PAUSED;
          end
        end else if (!(full_duplex_i && trigger_on_any_frame)) begin
          nxt_state = RFC_IDLE;
        end else if (at_high_ff && tx_enabled_i) begin
          nxt_pause_req  = 1'b1;
          nxt_pause_zero = 1'b0;
        end
      end
      RFC_PAUSED: begin
        if (pause_req_o) begin
          if (pause_ack_i) begin
            nxt_pause_req = 1'b0;
            nxt_state     = RFC_IDLE;
          end
        end else if (below_low_ff && fc_enabled && tx_enabled_i) begin
          nxt_pause_req  = 1'b1;
          nxt_pause_zero = 1'b1;
        end
      end
      default: begin
        nxt_state     = RFC_IDLE;
        nxt_pause_req = 1'b0;
      end
    endcase
    // A request clears at the first clock with the transmitter off and is never raised while it stays off
    if (!tx_enabled_i) begin
      nxt_pause_req = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff     <= RFC_IDLE;
      pause_req_o  <= 1'b0;
      pause_zero_o <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      pause_req_o  <= nxt_pause_req;
      pause_zero_o <= nxt_pause_zero;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      paused_o <= 1'b0;
    end else begin
      paused_o <= (nxt_state == RFC_PAUSED);
    end
  end

  // ----------------------------------------
  // Half-duplex backpressure
  // ----------------------------------------
  logic [BP_CNT_W-1:0] dur_cycles_w;
  logic [BP_CNT_W-1:0] bp_cnt_ff;
  logic                frame_hit;

  rfc_dur_rom u_dur_rom (
    .clk_i    (clk_i),
    .code_i   (backpressure_duration),
    .slow_i   (speed_10_i),
    .cycles_o (dur_cycles_w)
  );

  // Any-frame acts at the preamble with no address decode; else needs a decoded match
  always_comb begin
    if (trigger_on_any_frame) begin
      frame_hit = rx_preamble_i;
    end else begin
      frame_hit = rx_addr_valid_i &&
                  ((trigger_on_multicast   && rx_is_mcast_i) ||
                   (trigger_on_broadcast   && rx_is_bcast_i) ||
                   (trigger_on_own_address && rx_is_own_i));
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bp_cnt_ff      <= '0;
      backpressure_o <= 1'b0;
    end else if (!tx_enabled_i || full_duplex_i) begin
      // Full duplex never jams; duration field is unused there
      bp_cnt_ff      <= '0;
      backpressure_o <= 1'b0;
    end else if (at_high_ff && frame_hit) begin
      bp_cnt_ff      <= dur_cycles_w;
      backpressure_o <= 1'b1;
    end else if (bp_cnt_ff > BP_CNT_W'(1)) begin
      bp_cnt_ff      <= bp_cnt_ff - BP_CNT_W'(1);
      backpressure_o <= 1'b1;
    end else begin
      bp_cnt_ff      <= '0;
      backpressure_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  // Bit 31 reflects the paused flag; rest of the upper byte reads zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i && reg_addr_i == AUTO_FLOW_CONTROL_CONFIG_OFFSET) begin
      reg_rdata_o <= {paused_o, cfg_ff[30:0]};
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule

// [testbench/rfc_flow_ctrl_assertions.sv]
`timescale 1ns/100ps
module rfc_flow_ctrl_assertions (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic tx_enabled_i,
  input  wire logic full_duplex_i,
  input  wire logic pause_ack_i,
  input  wire logic pause_req_o,
  input  wire logic pause_zero_o,
  input  wire logic backpressure_o,
  input  wire logic paused_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_ack;
    pause_req_o && pause_ack_i;
  endsequence
  property p_tx_off;
    !tx_enabled_i ##1 !tx_enabled_i |-> !pause_req_o && !backpressure_o;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("flow control active with tx off");
  property p_fd_nobp;
    full_duplex_i ##1 full_duplex_i |-> !backpressure_o;
  endproperty
  a_fd_nobp: assert property (p_fd_nobp) else $error("jam in full duplex");
  property p_hold;
    pause_req_o && !pause_ack_i && tx_enabled_i && full_duplex_i |=> pause_req_o;
  endproperty
  a_hold: assert property (p_hold) else $error("pause request dropped unanswered");
  property p_drop;
    s_ack |=> !pause_req_o;
  endproperty
  a_drop: assert property (p_drop) else $error("pause request kept after ack");
  property p_set;
    s_ack ##0 !pause_zero_o |=> paused_o;
  endproperty
  a_set: assert property (p_set) else $error("paused flag not set");
  property p_clr;
    s_ack ##0 pause_zero_o |=> !paused_o;
  endproperty
  a_clr: assert property (p_clr) else $error("paused flag not cleared");
  property p_zero_after;
    $rose(pause_req_o) && pause_zero_o |-> paused_o;
  endproperty
  a_zero_after: assert property (p_zero_after) else $error("zero pause while not paused");
  property p_hi_pause;
    $rose(pause_req_o) && !paused_o |-> !pause_zero_o;
  endproperty
  a_hi_pause: assert property (p_hi_pause) else $error("first pause has zero time");
  // Shortest duration code is 100 cycles, so eight is a safe floor
  property p_bp_len;
    $rose(backpressure_o) && tx_enabled_i && !full_duplex_i |-> backpressure_o [*8];
  endproperty
  a_bp_len: assert property (p_bp_len) else $error("jam shorter than duration");
endmodule

bind rfc_flow_ctrl rfc_flow_ctrl_assertions i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .tx_enabled_i(tx_enabled_i), .full_duplex_i(full_duplex_i), .pause_ack_i(pause_ack_i),
  .pause_req_o(pause_req_o), .pause_zero_o(pause_zero_o), .backpressure_o(backpressure_o),
  .paused_o(paused_o));

// [testbench/rfc_mac_model.sv]
`timescale 1ns/100ps
module rfc_mac_model (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pause_req_i,
  input  wire logic slow_i,
  output logic      pause_ack_o
);
  logic [4:0] wait_ff;
  // Queued pause goes out after a short or a long transmit backlog
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !pause_req_i || pause_ack_o) begin
      wait_ff     <= 5'h00;
      pause_ack_o <= 1'b0;
    end else begin
      wait_ff     <= wait_ff + 5'h01;
      pause_ack_o <= (wait_ff == (slow_i ? 5'h14 : 5'h01));
    end
  end
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
  import rfc_pkg::*;
  logic        clk_i, sys_rst_i, reg_wr_i, reg_rd_i, tx_enabled_i, full_duplex_i, speed_10_i;
  logic        rx_preamble_i, rx_addr_valid_i, rx_is_mcast_i, rx_is_bcast_i, rx_is_own_i;
  logic        pause_ack_i, pause_req_o, pause_zero_o, backpressure_o, paused_o, slow;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, got;
  logic [13:0] rx_fifo_used_i;
  logic [11:0] rows [8];
  int          n_fail, checks, hi_cnt;

  rfc_flow_ctrl #(.FIFO_LVL_W(14)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .rx_fifo_used_i(rx_fifo_used_i),
    .tx_enabled_i(tx_enabled_i), .full_duplex_i(full_duplex_i), .speed_10_i(speed_10_i),
    .rx_preamble_i(rx_preamble_i), .rx_addr_valid_i(rx_addr_valid_i),
    .rx_is_mcast_i(rx_is_mcast_i), .rx_is_bcast_i(rx_is_bcast_i), .rx_is_own_i(rx_is_own_i),
    .pause_ack_i(pause_ack_i), .pause_req_o(pause_req_o), .pause_zero_o(pause_zero_o),
    .backpressure_o(backpressure_o), .paused_o(paused_o));
  rfc_mac_model i_mac (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pause_req_i(pause_req_o),
    .slow_i(slow), .pause_ack_o(pause_ack_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr(input logic [31:0] d);
    reg_addr_i = AUTO_FLOW_CONTROL_CONFIG_OFFSET;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  // Bounded wait on the request (sel 0) or the paused flag (sel 1)
  task automatic wait_for(input int sel, input logic v);
    int i;
    for (i = 0; i < 300 && (sel ? paused_o : pause_req_o) !== v; i++) cyc(1);
    if (i == 300) begin
      n_fail++;
      give_verdict();
    end
  endtask

  initial begin
    {reg_wr_i, reg_rd_i, tx_enabled_i, full_duplex_i, speed_10_i, rx_preamble_i} = '0;
    {rx_addr_valid_i, rx_is_mcast_i, rx_is_bcast_i, rx_is_own_i, slow} = '0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    rx_fifo_used_i = 14'h0;
    n_fail = 0;
    checks = 0;
    sys_rst_i = 1'b1;
    // Row: trigger bits, {preamble, mcast, bcast, own}, {slow speed, 0, 0, jam expected}
    rows = '{12'h841, 12'h820, 12'h421, 12'h219, 12'h240, 12'h940, 12'h181, 12'he80};
    cyc(12);
    sys_rst_i = 1'b0;
    // ----------------------------------------
    // Register access
    // ----------------------------------------
    rd(AUTO_FLOW_CONTROL_CONFIG_OFFSET, got); chk(got, AUTO_FLOW_CONTROL_CONFIG_RESET);
    wr(32'hffff_ffff); rd(AUTO_FLOW_CONTROL_CONFIG_OFFSET, got); chk(got, AUTO_FLOW_CONTROL_CONFIG_WMASK);
    rd(8'ha8, got); chk(got, 32'h0);
    // ----------------------------------------
    // Half duplex jam table
    // ----------------------------------------
    tx_enabled_i = 1'b1;
    rx_fifo_used_i = 14'h0c8;
    foreach (rows[r]) begin
      wr({24'h000201, 4'h0, rows[r][11:8]});
      speed_10_i = rows[r][3];
      cyc(2);
      {rx_preamble_i, rx_is_mcast_i, rx_is_bcast_i, rx_is_own_i} = rows[r][7:4];
      rx_addr_valid_i = |rows[r][6:4];
      cyc(1);
      {rx_preamble_i, rx_addr_valid_i} = 2'h0;
      hi_cnt = int'(backpressure_o);
      repeat (200) begin
        cyc(1);
        hi_cnt += backpressure_o;
      end
      chk(hi_cnt, rows[r][0] ? CLK_MHZ * 5 + (rows[r][3] ? SLOW_EXTRA_CYC : 0) : 0);
    end
    // ----------------------------------------
    // Full duplex pause pair
    // ----------------------------------------
    rx_fifo_used_i = 14'h0;
    full_duplex_i = 1'b1;
    wr(32'h0002_0101);
    cyc(2);
    rx_fifo_used_i = 14'h080;
    wait_for(0, 1'b1); chk(pause_zero_o, 1'b0);
    wait_for(1, 1'b1);
    rd(AUTO_FLOW_CONTROL_CONFIG_OFFSET, got); chk(got, 32'h8002_0101);
    cyc(30); chk(pause_req_o, 1'b0);
    slow = 1'b1;
    rx_fifo_used_i = 14'h040;
    cyc(30); chk(pause_req_o, 1'b0);
    rx_fifo_used_i = 14'h03f;
    wait_for(0, 1'b1); chk(pause_zero_o, 1'b1);
    wait_for(1, 1'b0);
    cyc(30); chk(pause_req_o, 1'b0);
    wr(32'h0002_010e);
    rx_fifo_used_i = 14'h0c8;
    cyc(30); chk(pause_req_o, 1'b0);
    // ----------------------------------------
    // Transmitter disabled
    // ----------------------------------------
    tx_enabled_i = 1'b0;
    wr(32'h0002_0101);
    cyc(30); chk(pause_req_o, 1'b0);
    full_duplex_i = 1'b0;
    rx_preamble_i = 1'b1;
    cyc(1);
    rx_preamble_i = 1'b0;
    cyc(5); chk(backpressure_o, 1'b0);
    give_verdict();
  end
endmodule
